// ===== hw/clock_startup_pkg.sv
package clock_startup_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] FUSE_OFFSET = 8'h00;
	localparam logic [7:0] CTRL_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int FUSE_SEL_LSB = 0;
	localparam int FUSE_SUT_LSB = 4;
	localparam int FUSE_DIV_BIT = 6;
	localparam int CTRL_SLEEP_BIT = 0;
	localparam int CTRL_DEEP_BIT = 1;
	localparam int CTRL_CONV_OFF_BIT = 2;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_SRC_LSB = 4;
	localparam int STAT_RANGE_LSB = 8;
	localparam int STAT_NOIRQ_BIT = 12;

	// ------------------------------------------------------------
	// Fuse encodings (one = unprogrammed, zero = programmed)
	// ------------------------------------------------------------
	localparam logic [3:0] SEL_RC128 = 4'h3;
	localparam logic [3:0] SEL_RC_CAL = 4'h2;
	localparam logic [3:0] SEL_RESERVED = 4'h1;
	localparam logic [3:0] SEL_EXTERNAL = 4'h0;
	localparam logic [3:0] SEL_FULL_SWING_LO = 4'h6;
	localparam logic [3:0] SEL_LOW_FREQ_LO = 4'h4;
	localparam logic [3:0] SEL_LOW_POWER_LO = 4'h8;
	localparam logic FUSE_PROGRAMMED = 1'b0;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [3:0] SEL_RESET = 4'h2;
	localparam logic [1:0] SUT_RESET = 2'h2;
	localparam logic DIV_RESET = 1'b0;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// ------------------------------------------------------------
	// Timing counts, in cycles of the counted oscillator
	// ------------------------------------------------------------
	localparam int TOUT_SHORT = 512;
	localparam int TOUT_LONG = 8192;
	localparam int SU_258 = 258;
	localparam int SU_1K = 1024;
	localparam int SU_16K = 16384;
	localparam int SU_32K = 32768;
	localparam int SU_EXT = 6;
	localparam int SU_RESET_EXTRA = 14;
	localparam int SU_LF_EXTRA = 4;
	localparam int DIV_RATIO = 8;

	typedef struct packed {
		logic div8;
		logic [1:0] startup_time_fuses;
		logic [3:0] sel;
	} fuse_s;

	typedef struct packed {
		logic core;
		logic peripheral;
		logic program_memory;
		logic async_timer;
		logic converter;
	} clock_gate_s;

	typedef enum logic [2:0] {
		src_low_power,
		src_full_swing,
		src_low_freq,
		src_rc128,
		src_rc_cal,
		src_external,
		src_reserved
	} source_e;

endpackage

// ===== hw/clock_source_startup_sequencer.sv
// Function
// - Decode clock select fuses into source class
// - Fuse one is unprogrammed, zero programmed
// - Default: calibrated RC, divide by eight, STARTUP_TIME_FUSES 10
// - Programmed divide fuse divides source by eight
// - Extra time-out after other resets release
// - Time-out counts watchdog cycles, fuse chosen
// - Time-out lengths 0, 512 or 8192
// - Ripple count of oscillator cycles holds reset
// - Reset: time-out plus start-up; deep wake: start-up only; idle wake: neither
// - Low power range from select bits 2:1
// - Select bit zero clear start-up table
// - Select bit zero set start-up table
// - Independent gates per clock domain
// - Program memory clock follows core clock
// - Async timer clock runs during sleep
// - Converter clock stays while core halted
// - Wake level dropped early: wake, no interrupt
// - Start-up counts from 6 up to 32K
`timescale 1ns/100ps
module clock_source_startup_sequencer
	import clock_startup_pkg::*;
#(
	parameter int TIMEOUT_LONG = clock_startup_pkg::TOUT_LONG,
	parameter int STARTUP_16K = clock_startup_pkg::SU_16K,
	parameter int STARTUP_32K = clock_startup_pkg::SU_32K
)
(
	input wire logic clock,
	input wire logic srst,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	input wire logic other_reset_active,
	input wire logic watchdog_osc,
	input wire logic selected_osc,
	input wire logic wake_level,
	output logic internal_reset,
	output logic system_tick,
	output clock_startup_pkg::clock_gate_s gates,
	output logic wake_interrupt
);

	typedef enum logic [2:0] {
		st_hold,
		st_timeout,
		st_startup,
		st_run,
		st_sleep
	} seq_e;

	// ------------------------------------------------------------
	// Input synchronisers, three stages, filtered on agreement
	// ------------------------------------------------------------
	logic [3:0] pin_raw;
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic [3:0] s3_q;
	logic [3:0] pin_q;
	logic [3:0] pin_prev_q;
	logic ext_reset;
	logic wdt_edge;
	logic osc_edge;
	logic wake_in;

	assign pin_raw = {wake_level, selected_osc, watchdog_osc,
		other_reset_active};

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			s1_q <= 4'h0;
			s2_q <= 4'h0;
			s3_q <= 4'h0;
		end
		else
		begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	generate
		for (genvar i = 0; i < 4; i++)
		begin : g_filter
			always_ff @(posedge clock)
			begin
				if (srst)
					pin_q[i] <= 1'b0;
				else if (s2_q[i] == s3_q[i])
					pin_q[i] <= s3_q[i];
			end
		end
	endgenerate

	always_ff @(posedge clock)
	begin
		if (srst)
			pin_prev_q <= 4'h0;
		else
			pin_prev_q <= pin_q;
	end

	assign ext_reset = pin_q[0];
	assign wdt_edge = pin_q[1] & ~pin_prev_q[1];
	assign osc_edge = pin_q[2] & ~pin_prev_q[2];
	assign wake_in = pin_q[3];

	// ------------------------------------------------------------
	// Registers and Wishbone slave
	// ------------------------------------------------------------
	fuse_s fuse_reg_q;
	fuse_s fuse_q;
	logic [2:0] ctrl_q;
	logic wake_noirq_q;
	seq_e state_q;
	source_e src_q;
	logic [1:0] range_q;
	logic wb_req;
	logic wr_ok;

	assign wb_req = wb_cyc & wb_stb & ~wb_ack;
	assign wr_ok = wb_req & wb_we & wb_sel[0];

	always_ff @(posedge clock)
	begin
		if (srst)
			fuse_reg_q <= '{div8: DIV_RESET, startup_time_fuses: SUT_RESET,
				sel: SEL_RESET};
		else if (wr_ok && wb_adr == FUSE_OFFSET)
			fuse_reg_q <= fuse_s'(wb_dat_w[6:0]);
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			ctrl_q <= CTRL_RESET;
		else if (wr_ok && wb_adr == CTRL_OFFSET)
			ctrl_q <= wb_dat_w[2:0];
		else if (state_q == st_sleep && wake_in)
			ctrl_q[CTRL_SLEEP_BIT] <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			wb_ack <= 1'b0;
		else
			wb_ack <= wb_req;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			wb_dat_r <= 32'h0000_0000;
		else if (wb_req && !wb_we)
		begin
			wb_dat_r <= 32'h0000_0000;
			unique case (wb_adr)
				FUSE_OFFSET: wb_dat_r[6:0] <= fuse_reg_q;
				CTRL_OFFSET: wb_dat_r[2:0] <= ctrl_q;
				STATUS_OFFSET:
				begin
					wb_dat_r[STAT_STATE_LSB +: 3] <= state_q;
					wb_dat_r[STAT_SRC_LSB +: 3] <= src_q;
					wb_dat_r[STAT_RANGE_LSB +: 2] <= range_q;
					wb_dat_r[STAT_NOIRQ_BIT] <= wake_noirq_q;
				end
				default: wb_dat_r <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Fuse decode
	// ------------------------------------------------------------
	source_e src_d;
	logic [13:0] tout_d;
	logic [15:0] su_wake_d;
	logic [15:0] su_reset_d;

	always_comb
	begin
		if (fuse_q.sel >= SEL_LOW_POWER_LO)
			src_d = src_low_power;
		else if (fuse_q.sel >= SEL_FULL_SWING_LO)
			src_d = src_full_swing;
		else if (fuse_q.sel >= SEL_LOW_FREQ_LO)
			src_d = src_low_freq;
		else if (fuse_q.sel == SEL_RC128)
			src_d = src_rc128;
		else if (fuse_q.sel == SEL_RC_CAL)
			src_d = src_rc_cal;
		else if (fuse_q.sel == SEL_EXTERNAL)
			src_d = src_external;
		else
			src_d = src_reserved;
	end

	always_comb
	begin
		tout_d = 14'(0);
		su_wake_d = 16'(SU_EXT);
		su_reset_d = 16'(SU_EXT);
		if (src_d == src_low_power || src_d == src_full_swing)
		begin
			unique case ({fuse_q.sel[0], fuse_q.startup_time_fuses})
				3'h0: begin su_wake_d = 16'(SU_258);
					tout_d = 14'(TOUT_SHORT); end
				3'h1: begin su_wake_d = 16'(SU_258);
					tout_d = 14'(TIMEOUT_LONG); end
				3'h2: su_wake_d = 16'(SU_1K);
				3'h3: begin su_wake_d = 16'(SU_1K);
					tout_d = 14'(TOUT_SHORT); end
				3'h4: begin su_wake_d = 16'(SU_1K);
					tout_d = 14'(TIMEOUT_LONG); end
				3'h5: su_wake_d = 16'(STARTUP_16K);
				3'h6: begin su_wake_d = 16'(STARTUP_16K);
					tout_d = 14'(TOUT_SHORT); end
				3'h7: begin su_wake_d = 16'(STARTUP_16K);
					tout_d = 14'(TIMEOUT_LONG); end
			endcase
			su_reset_d = su_wake_d + 16'(SU_RESET_EXTRA);
		end
		else
		begin
			unique case (fuse_q.startup_time_fuses)
				2'h0: tout_d = 14'(0);
				2'h1: tout_d = 14'(TOUT_SHORT);
				default: tout_d = 14'(TIMEOUT_LONG);
			endcase
			if (src_d == src_low_freq)
			begin
				su_wake_d = fuse_q.sel[0] ? 16'(STARTUP_32K - 1)
					: 16'(SU_1K);
				su_reset_d = su_wake_d + 16'(SU_LF_EXTRA);
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			src_q <= src_rc_cal;
			range_q <= 2'h0;
		end
		else
		begin
			src_q <= src_d;
			range_q <= (src_d == src_low_power) ?
				fuse_q.sel[2:1] : 2'h0;
		end
	end

	// ------------------------------------------------------------
	// Start-up sequencer
	// ------------------------------------------------------------
	logic [13:0] wdt_cnt_q;
	logic [15:0] osc_cnt_q;
	logic [15:0] su_target_q;
	logic from_reset_q;

	always_ff @(posedge clock)
	begin
		if (srst)
			fuse_q <= '{div8: DIV_RESET, startup_time_fuses: SUT_RESET,
				sel: SEL_RESET};
		else if (state_q == st_hold && !ext_reset)
			fuse_q <= fuse_reg_q;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			state_q <= st_hold;
		else if (ext_reset)
			state_q <= st_hold;
		else
		begin
			unique case (state_q)
				st_hold: state_q <= st_timeout;
				st_timeout:
					if (wdt_cnt_q >= tout_d)
						state_q <= st_startup;
				st_startup:
					if (osc_cnt_q >= su_target_q)
						state_q <= st_run;
				st_run:
					if (ctrl_q[CTRL_SLEEP_BIT])
						state_q <= st_sleep;
				st_sleep:
					if (wake_in)
						state_q <= ctrl_q[CTRL_DEEP_BIT] ?
							st_startup : st_run;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			from_reset_q <= 1'b1;
		else if (ext_reset || state_q == st_hold)
			from_reset_q <= 1'b1;
		else if (state_q == st_run)
			from_reset_q <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (srst || state_q != st_timeout)
			wdt_cnt_q <= 14'h0000;
		else if (wdt_edge)
			wdt_cnt_q <= wdt_cnt_q + 14'h0001;
	end

	always_ff @(posedge clock)
	begin
		if (srst || state_q != st_startup)
			osc_cnt_q <= 16'h0000;
		else if (osc_edge)
			osc_cnt_q <= osc_cnt_q + 16'h0001;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			su_target_q <= 16'(SU_EXT);
		else if (state_q == st_timeout)
			su_target_q <= su_reset_d;
		else if (state_q == st_sleep)
			su_target_q <= su_wake_d;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			internal_reset <= 1'b1;
		else
			internal_reset <= state_q inside {st_hold, st_timeout,
				st_startup} && from_reset_q;
	end

	// ------------------------------------------------------------
	// Wake interrupt qualification
	// ------------------------------------------------------------
	logic startup_done;

	assign startup_done = state_q == st_startup && !from_reset_q
		&& osc_cnt_q >= su_target_q && !ext_reset;

	always_ff @(posedge clock)
	begin
		if (srst)
			wake_interrupt <= 1'b0;
		else
			wake_interrupt <= (startup_done && wake_in)
				|| (state_q == st_sleep && wake_in
				&& !ctrl_q[CTRL_DEEP_BIT]);
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			wake_noirq_q <= 1'b0;
		else if (startup_done)
			wake_noirq_q <= ~wake_in;
	end

	// ------------------------------------------------------------
	// Divider and clock gates
	// ------------------------------------------------------------
	logic [2:0] div_cnt_q;

	always_ff @(posedge clock)
	begin
		if (srst)
			div_cnt_q <= 3'h0;
		else if (osc_edge)
			div_cnt_q <= div_cnt_q + 3'h1;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			system_tick <= 1'b0;
		else if (fuse_q.div8 == FUSE_PROGRAMMED)
			system_tick <= osc_edge && div_cnt_q == 3'(DIV_RATIO - 1);
		else
			system_tick <= osc_edge;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			gates <= '0;
		else
		begin
			gates.core <= state_q == st_run;
			gates.program_memory <= state_q == st_run;
			gates.peripheral <= state_q == st_run
				|| (state_q == st_sleep && !ctrl_q[CTRL_DEEP_BIT]);
			gates.async_timer <= 1'b1;
			gates.converter <= !ctrl_q[CTRL_CONV_OFF_BIT];
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_sleep_wake;
		state_q == st_sleep && wake_in && ctrl_q[CTRL_DEEP_BIT]
			&& !ext_reset;
	endsequence

	a_default_fuse: assert property (@(posedge clock)
		$fell(srst) |-> fuse_reg_q == 7'h22)
		else $error("fuse defaults wrong after reset");

	a_fuse_stable: assert property (@(posedge clock) disable iff (srst)
		state_q != st_hold && $past(state_q) != st_hold
		|-> $stable(fuse_q))
		else $error("fuses changed during sequence");

	a_reset_after_other: assert property (@(posedge clock)
		disable iff (srst)
		ext_reset |=> ##1 internal_reset)
		else $error("internal reset not held");

	a_deep_wake_path: assert property (@(posedge clock)
		disable iff (srst)
		s_sleep_wake |=> state_q == st_startup ##1 !internal_reset)
		else $error("wake applied time-out or reset");

	a_timeout_zero: assert property (@(posedge clock)
		disable iff (srst)
		state_q == st_timeout && tout_d == 14'h0 && !ext_reset
		|=> state_q == st_startup)
		else $error("zero time-out not skipped");

	a_startup_hold: assert property (@(posedge clock)
		disable iff (srst)
		state_q == st_startup && osc_cnt_q < su_target_q
		|=> state_q != st_run)
		else $error("run before start-up count");

	a_flash_core: assert property (@(posedge clock)
		disable iff (srst)
		gates.program_memory == gates.core)
		else $error("program memory clock split from core");

	a_async_runs: assert property (@(posedge clock)
		disable iff (srst)
		$past(srst) == 1'b0 |-> gates.async_timer)
		else $error("async timer clock stopped");

	a_div_tick: assert property (@(posedge clock)
		disable iff (srst)
		system_tick && fuse_q.div8 == FUSE_PROGRAMMED
		|-> $past(div_cnt_q) == 3'h7)
		else $error("divided tick off ratio");

	a_ack_pulse: assert property (@(posedge clock)
		disable iff (srst)
		wb_ack |=> !wb_ack)
		else $error("ack held over two cycles");

endmodule

// ===== sim/clock_source_startup_sequencer_tb.sv
`timescale 1ns/100ps
module clock_source_startup_sequencer_tb;
	import clock_startup_pkg::*;
	logic clock, srst, wb_cyc, wb_stb, wb_we, wb_ack;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat_w, wb_dat_r, rd;
	logic other_reset_active, watchdog_osc, selected_osc, wake_level;
	logic internal_reset, system_tick, wake_interrupt, wd_run, osc_run;
	logic [1:0] ph;
	clock_gate_s gates;
	int num_errors, total_checks, wd_edges, osc_edges, ticks, irqs;

	clock_source_startup_sequencer #(
		.TIMEOUT_LONG(600),
		.STARTUP_16K(700),
		.STARTUP_32K(800)
	) u_dut (
		.clock(clock),
		.srst(srst),
		.wb_cyc(wb_cyc),
		.wb_stb(wb_stb),
		.wb_we(wb_we),
		.wb_adr(wb_adr),
		.wb_sel(wb_sel),
		.wb_dat_w(wb_dat_w),
		.wb_dat_r(wb_dat_r),
		.wb_ack(wb_ack),
		.other_reset_active(other_reset_active),
		.watchdog_osc(watchdog_osc),
		.selected_osc(selected_osc),
		.wake_level(wake_level),
		.internal_reset(internal_reset),
		.system_tick(system_tick),
		.gates(gates),
		.wake_interrupt(wake_interrupt)
	);

	// ----------------------------------------
	// Clock and oscillator waveforms
	// ----------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// Oscillators run at a quarter of the clock rate and stand still when off
	always @(posedge clock)
	begin
		ph <= ph + 2'h1;
		if (wd_run && ph[0])
		begin
			watchdog_osc <= ~watchdog_osc;
			wd_edges <= wd_edges + int'(!watchdog_osc);
		end
		if (osc_run && ph[0])
		begin
			selected_osc <= ~selected_osc;
			osc_edges <= osc_edges + int'(!selected_osc);
		end
		ticks <= ticks + int'(system_tick === 1'b1);
		irqs <= irqs + int'(wake_interrupt === 1'b1);
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic conclude;
		$display("checks %0d, errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask

	task automatic check_in(string what, int lo, int hi, int got);
		total_checks++;
		if (got < lo || got > hi)
		begin
			num_errors++;
			$display("unexpected %s: expected %0d..%0d, seen %0d",
				what, lo, hi, got);
		end
	endtask

	task automatic cycles(int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic wb(logic we, logic [3:0] sel, logic [7:0] adr,
		logic [31:0] dat);
		int n = 0;
		@(posedge clock);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_sel <= sel;
		wb_adr <= adr;
		wb_dat_w <= dat;
		@(posedge clock);
		while (wb_ack !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge clock);
		end
		if (n >= 50)
			check("wb_ack", 32'h1, 32'h0);
		rd = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask

	task automatic restart(logic [7:0] fuse);
		wb(1'b1, 4'hF, FUSE_OFFSET, {24'h0, fuse});
		@(posedge clock);
		other_reset_active <= 1'b1;
		cycles(8);
		other_reset_active <= 1'b0;
	endtask

	function automatic logic [2:0] src_of(logic [3:0] s);
		if (s[3])
			return 3'h0;
		case (s)
			4'h7, 4'h6: return 3'h1;
			4'h5, 4'h4: return 3'h2;
			4'h3: return 3'h3;
			4'h2: return 3'h4;
			4'h0: return 3'h5;
			default: return 3'h6;
		endcase
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		check("internal_reset", 32'h1, internal_reset);
		wb(1'b0, 4'hF, FUSE_OFFSET, 32'h0);
		check("fuse default", 32'h22, rd);
		wb(1'b1, 4'h0, FUSE_OFFSET, 32'h7F);
		wb(1'b0, 4'hF, FUSE_OFFSET, 32'h0);
		check("fuse no lane", 32'h22, rd);
		wb(1'b0, 4'hF, CTRL_OFFSET, 32'h0);
		check("ctrl default", 32'h0, rd);
		wb(1'b1, 4'hF, 8'h0C, 32'hFF);
		wb(1'b0, 4'hF, 8'h0C, 32'h0);
		check("unmapped", 32'h0, rd);
		wb(1'b0, 4'hF, STATUS_OFFSET, 32'h0);
		check("status default", 32'h41, rd);
	endtask

	task automatic t_decode;
		for (int s = 0; s < 16; s++)
		begin
			restart(8'h40 | 8'(s));
			cycles(10);
			wb(1'b0, 4'hF, STATUS_OFFSET, 32'h0);
			check("source", src_of(4'(s)), rd[6:4]);
			check("range", s > 7 ? 32'(s[2:1]) : 32'h0, rd[9:8]);
		end
	endtask

	task automatic t_timing(logic [7:0] fuse, int tout, int su);
		int w0;
		int o0;
		int n = 0;
		wd_run <= 1'b1;
		osc_run <= 1'b0;
		restart(fuse);
		w0 = wd_edges;
		rd = 32'h0;
		while (rd[2:0] < 3'h2 && n < 3000)
		begin
			wb(1'b0, 4'hF, STATUS_OFFSET, 32'h0);
			n++;
		end
		check_in("timeout edges", tout, tout + 3, wd_edges - w0);
		wd_run <= 1'b0;
		wb(1'b1, 4'hF, FUSE_OFFSET, 32'h4F);
		cycles(40);
		check("held reset", 32'h1, internal_reset);
		o0 = osc_edges;
		osc_run <= 1'b1;
		n = 0;
		while (internal_reset !== 1'b0 && n < 20000)
		begin
			@(posedge clock);
			n++;
		end
		check_in("startup edges", su, su + 4, osc_edges - o0);
		cycles(3);
		check("gates run", 32'h1F, gates);
		wb(1'b0, 4'hF, STATUS_OFFSET, 32'h0);
		check("latched source", src_of(fuse[3:0]), rd[6:4]);
	endtask

	task automatic t_div(int ratio);
		int o0;
		int t0;
		int d;
		o0 = osc_edges;
		t0 = ticks;
		cycles(640);
		d = (osc_edges - o0) / ratio;
		check_in("ticks", d - 1, d + 1, ticks - t0);
	endtask

	task automatic t_idle;
		int i0;
		wb(1'b1, 4'hF, CTRL_OFFSET, 32'h1);
		cycles(6);
		check("core gate", 32'h0, gates.core);
		check("memory gate", 32'h0, gates.program_memory);
		check("idle peripheral gate", 32'h1, gates.peripheral);
		check("async gate", 32'h1, gates.async_timer);
		check("converter gate", 32'h1, gates.converter);
		i0 = irqs;
		wake_level <= 1'b1;
		cycles(20);
		wake_level <= 1'b0;
		check("idle interrupt", 32'h1, irqs - i0);
		check("memory gate", 32'h1, gates.program_memory);
		wb(1'b0, 4'hF, CTRL_OFFSET, 32'h0);
		check("sleep cleared", 32'h0, rd);
		wb(1'b1, 4'hF, CTRL_OFFSET, 32'h4);
		cycles(4);
		check("converter off", 32'h0, gates.converter);
		wb(1'b1, 4'hF, CTRL_OFFSET, 32'h0);
	endtask

	task automatic t_deep(logic hold);
		int i0;
		int o0;
		int n = 0;
		logic seen = 1'b0;
		i0 = irqs;
		osc_run <= 1'b0;
		wb(1'b1, 4'hF, CTRL_OFFSET, 32'h3);
		cycles(6);
		check("deep core gate", 32'h0, gates.core);
		check("deep async gate", 32'h1, gates.async_timer);
		check("deep peripheral gate", 32'h0, gates.peripheral);
		wake_level <= 1'b1;
		cycles(12);
		wake_level <= hold;
		cycles(20);
		o0 = osc_edges;
		osc_run <= 1'b1;
		while (gates.core !== 1'b1 && n < 6000)
		begin
			@(posedge clock);
			seen = seen | internal_reset;
			n++;
		end
		check_in("wake edges", 1024, 1029, osc_edges - o0);
		cycles(4);
		wake_level <= 1'b0;
		check("wake reset", 32'h0, seen);
		check("deep interrupt", 32'(hold), irqs - i0);
		wb(1'b0, 4'hF, STATUS_OFFSET, 32'h0);
		check("level dropped", 32'(!hold), rd[12]);
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		srst = 1'b1;
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} = '0;
		{other_reset_active, watchdog_osc, selected_osc} = 3'h0;
		{wake_level, wd_run, osc_run, ph} = 5'h00;
		{num_errors, total_checks, wd_edges, osc_edges, ticks, irqs} = '0;
		cycles(8);
		srst <= 1'b0;
		t_reset();
		t_decode();
		t_timing(8'h52, 512, 6);
		t_timing(8'h60, 600, 6);
		t_timing(8'h48, 512, 272);
		t_timing(8'h59, 0, 714);
		t_timing(8'h44, 0, SU_1K + SU_LF_EXTRA);
		t_timing(8'h45, 0, 800 - 1 + SU_LF_EXTRA);
		t_div(1);
		t_timing(8'h04, 0, SU_1K + SU_LF_EXTRA);
		t_div(8);
		t_idle();
		t_deep(1'b1);
		t_deep(1'b0);
		conclude();
	end

	initial
	begin
		#(100 * 80000);
		num_errors++;
		conclude();
	end
endmodule
